// File: pkg/rsbmc_defs.vh
`ifndef RSBMC_DEFS_VH
`define RSBMC_DEFS_VH

// register byte addresses
`define RSBMC_ADDR_CTRL        8'h00
`define RSBMC_ADDR_LAT         8'h04
`define RSBMC_ADDR_STATUS      8'h08

// rx_buffer_control fields
`define RSBMC_MODE_LSB         0
`define RSBMC_MODE_MSB         1
`define RSBMC_SDIR_BIT         2
`define RSBMC_CTRL_RESET       8'h00
`define RSBMC_CTRL_WMASK       8'h07

// rx_fifo_latency_cfg fields
`define RSBMC_LAT_MSB          4
`define RSBMC_LAT_RESET        5'h04

// mode codes
`define RSBMC_MODE_SLIP        2'b01
`define RSBMC_MODE_FIFO        2'b10

// axi responses
`define RSBMC_RESP_OKAY        2'b00
`define RSBMC_RESP_SLVERR      2'b10

// fifo geometry
`define RSBMC_FIFO_DEPTH       4
`define RSBMC_FIFO_AW          2
`define RSBMC_LAT_DEPTH        32

`endif

// File: hw/rsbmc_fifo.v
// small ready/valid fifo held in flip-flops
module rsbmc_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wptr_reg;
    reg [AW-1:0]    rptr_reg;
    reg [AW:0]      count_reg;

    localparam [AW:0] DEPTH_W = DEPTH;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != DEPTH_W);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rptr_reg];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wptr_reg  <= {AW{1'b0}};
            rptr_reg  <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem_reg[wptr_reg] <= in_data;
                wptr_reg          <= wptr_reg + 1'b1;
            end
            if (pop)
                rptr_reg <= rptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule // rsbmc_fifo

// File: hw/rsbmc_top.v
`include "rsbmc_defs.vh"

// Operation
// - Mode code 00 or 11 bypasses the buffer and drives clock and sync pins as outputs.
// - Mode code 01 runs the buffer as a slip buffer, code 10 as a fifo.
// - In slip and fifo modes the backplane clock pin is an input supplied from outside.
// - With the buffer enabled, sync is an output when the direction bit is 0, input if 1.
// - In fifo mode data is delayed by the five-bit latency in backplane clock periods.
// - The latency field resets to four and its upper three register bits are reserved.
// - The latency setting has no effect unless fifo mode is selected.
module rsbmc_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        line_data,
    input  wire        line_clk,
    input  wire        line_sync,
    input  wire        rx_backplane_clock_i,
    output reg         rx_backplane_clock_o,
    output reg         rx_backplane_clock_oe,
    input  wire        rx_frame_sync_i,
    output reg         rx_frame_sync_o,
    output reg         rx_frame_sync_oe,
    output reg         rx_data_out,
    output reg         rx_buffer_slip
);
    // modes as one-hot states
    localparam ST_BYPASS = 3'b001;
    localparam ST_SLIP   = 3'b010;
    localparam ST_FIFO   = 3'b100;

    reg [7:0]  rx_buffer_control_reg;
    reg [4:0]  lat_reg;
    reg [2:0]  mode_reg;
    reg [2:0]  mode_next;
    reg [3:0]  fifo_level_reg;

    // ---------------- pin synchronisers ----------------
    reg [1:0] lclk_sync_reg;
    reg [1:0] ldat_sync_reg;
    reg [1:0] lsyn_sync_reg;
    reg [1:0] bclk_sync_reg;
    reg [1:0] fsyn_sync_reg;
    reg       lclk_prev_reg;
    reg       bclk_prev_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lclk_sync_reg <= 2'b00;
            ldat_sync_reg <= 2'b00;
            lsyn_sync_reg <= 2'b00;
            bclk_sync_reg <= 2'b00;
            fsyn_sync_reg <= 2'b00;
            lclk_prev_reg <= 1'b0;
            bclk_prev_reg <= 1'b0;
        end
        else
        begin
            lclk_sync_reg <= {lclk_sync_reg[0], line_clk};
            ldat_sync_reg <= {ldat_sync_reg[0], line_data};
            lsyn_sync_reg <= {lsyn_sync_reg[0], line_sync};
            bclk_sync_reg <= {bclk_sync_reg[0], rx_backplane_clock_i};
            fsyn_sync_reg <= {fsyn_sync_reg[0], rx_frame_sync_i};
            lclk_prev_reg <= lclk_sync_reg[1];
            bclk_prev_reg <= bclk_sync_reg[1];
        end
    end

    wire line_rise = lclk_sync_reg[1] && !lclk_prev_reg;
    wire line_fall = !lclk_sync_reg[1] && lclk_prev_reg;
    wire bp_rise   = bclk_sync_reg[1] && !bclk_prev_reg;
    wire sdir_in   = rx_buffer_control_reg[`RSBMC_SDIR_BIT];

    // ---------------- mode decode ----------------
    always @*
    begin
        case (rx_buffer_control_reg[`RSBMC_MODE_MSB:`RSBMC_MODE_LSB])
            `RSBMC_MODE_SLIP: mode_next = ST_SLIP;
            `RSBMC_MODE_FIFO: mode_next = ST_FIFO;
            default:          mode_next = ST_BYPASS;
        endcase
    end

    // ---------------- axi4-lite slave ----------------
    reg [7:0]  aw_addr_reg;
    reg        aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        w_held_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready         <= 1'b0;
            s_axi_wready          <= 1'b0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `RSBMC_RESP_OKAY;
            s_axi_arready         <= 1'b0;
            s_axi_rvalid          <= 1'b0;
            s_axi_rresp           <= `RSBMC_RESP_OKAY;
            s_axi_rdata           <= 32'h0000_0000;
            aw_addr_reg           <= 8'h00;
            aw_held_reg           <= 1'b0;
            w_data_reg            <= 32'h0000_0000;
            w_strb_reg            <= 4'h0;
            w_held_reg            <= 1'b0;
            rx_buffer_control_reg <= `RSBMC_CTRL_RESET;
            lat_reg               <= `RSBMC_LAT_RESET;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            if (s_axi_awvalid && !aw_held_reg && !s_axi_awready && !s_axi_bvalid)
            begin
                s_axi_awready <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                aw_held_reg   <= 1'b1;
            end
            if (s_axi_wvalid && !w_held_reg && !s_axi_wready && !s_axi_bvalid)
            begin
                s_axi_wready <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_held_reg   <= 1'b1;
            end
            if (aw_held_reg && w_held_reg && !s_axi_bvalid)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RSBMC_RESP_OKAY;
                case (aw_addr_reg)
                    `RSBMC_ADDR_CTRL:
                        if (w_strb_reg[0])
                            rx_buffer_control_reg <= w_data_reg[7:0] & `RSBMC_CTRL_WMASK;
                    `RSBMC_ADDR_LAT:
                        if (w_strb_reg[0])
                            lat_reg <= w_data_reg[`RSBMC_LAT_MSB:0];
                    `RSBMC_ADDR_STATUS: ;
                    default:
                        s_axi_bresp <= `RSBMC_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;

            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `RSBMC_RESP_OKAY;
                case (s_axi_araddr)
                    `RSBMC_ADDR_CTRL:
                        s_axi_rdata <= {24'h00_0000, rx_buffer_control_reg};
                    `RSBMC_ADDR_LAT:
                        s_axi_rdata <= {27'h000_0000, lat_reg};
                    `RSBMC_ADDR_STATUS:
                        s_axi_rdata <= {24'h00_0000, 1'b0, fifo_level_reg, mode_reg};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RSBMC_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- line side into the fifo ----------------
    wire       fin_ready;
    wire       fout_valid;
    wire [1:0] fout_data;
    reg        fin_valid_reg;
    reg  [1:0] fin_data_reg;
    wire       fout_ready = bp_rise && (mode_reg != ST_BYPASS) && fout_valid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fin_valid_reg  <= 1'b0;
            fin_data_reg   <= 2'b00;
            fifo_level_reg <= 4'h0;
            rx_buffer_slip <= 1'b0;
            mode_reg       <= ST_BYPASS;
        end
        else
        begin
            mode_reg       <= mode_next;
            rx_buffer_slip <= 1'b0;
            if (fin_valid_reg && fin_ready)
                fin_valid_reg <= 1'b0;
            if (line_rise && mode_reg != ST_BYPASS)
            begin
                // a full buffer lets the new line bit overwrite the waiting one: that is a slip
                if (fin_valid_reg && !fin_ready)
                    rx_buffer_slip <= 1'b1;
                fin_valid_reg <= 1'b1;
                fin_data_reg  <= {lsyn_sync_reg[1], ldat_sync_reg[1]};
            end
            if ((fin_valid_reg && fin_ready) && !fout_ready)
                fifo_level_reg <= fifo_level_reg + 4'h1;
            else if (!(fin_valid_reg && fin_ready) && fout_ready)
                fifo_level_reg <= fifo_level_reg - 4'h1;
        end
    end

    rsbmc_fifo #(
        .WIDTH (2),
        .DEPTH (`RSBMC_FIFO_DEPTH),
        .AW    (`RSBMC_FIFO_AW)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (fin_data_reg),
        .in_valid  (fin_valid_reg),
        .in_ready  (fin_ready),
        .out_data  (fout_data),
        .out_valid (fout_valid),
        .out_ready (fout_ready)
    );

    // ---------------- latency line on the backplane clock ----------------
    // bits shift once per backplane clock period, so tap n is n periods late
    reg [`RSBMC_LAT_DEPTH-1:0] delay_reg;
    reg                        slip_bit_reg;
    reg                        slip_sync_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            delay_reg     <= 32'h0000_0000;
            slip_bit_reg  <= 1'b0;
            slip_sync_reg <= 1'b0;
        end
        else if (bp_rise)
        begin
            delay_reg     <= {delay_reg[`RSBMC_LAT_DEPTH-2:0],
                              fout_valid ? fout_data[0] : 1'b0};
            slip_bit_reg  <= fout_valid ? fout_data[0] : slip_bit_reg;
            slip_sync_reg <= fout_valid && fout_data[1];
        end
    end

    // ---------------- pin outputs ----------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_backplane_clock_o  <= 1'b0;
            rx_backplane_clock_oe <= 1'b1;
            rx_frame_sync_o       <= 1'b0;
            rx_frame_sync_oe      <= 1'b1;
            rx_data_out           <= 1'b0;
        end
        else
        begin
            case (mode_reg)
                ST_BYPASS:
                begin
                    rx_backplane_clock_oe <= 1'b1;
                    rx_frame_sync_oe      <= 1'b1;
                    rx_backplane_clock_o  <= lclk_sync_reg[1];
                    rx_frame_sync_o       <= lsyn_sync_reg[1];
                    if (line_fall)
                        rx_data_out <= ldat_sync_reg[1];
                end
                ST_SLIP:
                begin
                    rx_backplane_clock_oe <= 1'b0;
                    rx_backplane_clock_o  <= 1'b0;
                    rx_frame_sync_oe      <= !sdir_in;
                    rx_frame_sync_o       <= slip_sync_reg;
                    rx_data_out           <= slip_bit_reg;
                end
                ST_FIFO:
                begin
                    rx_backplane_clock_oe <= 1'b0;
                    rx_backplane_clock_o  <= 1'b0;
                    rx_frame_sync_oe      <= !sdir_in;
                    rx_frame_sync_o       <= slip_sync_reg;
                    // latency only applies here; tap n lags the newest bit by n periods,
                    // so zero shows the bit popped at the last backplane clock rise
                    rx_data_out <= delay_reg[lat_reg];
                end
                default:
                begin
                    rx_backplane_clock_oe <= 1'b1;
                    rx_frame_sync_oe      <= 1'b1;
                end
            endcase
        end
    end

    // input sync is sampled but trusted to be aligned to the backplane clock
    wire unused_fsync = fsyn_sync_reg[1];
endmodule // rsbmc_top

// File: tb/rsbmc_monitor.sv
module rsbmc_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        rx_backplane_clock_oe,
    input wire logic        rx_frame_sync_oe,
    input wire logic        rx_buffer_slip
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] a_reg;
    logic [3:0] d_reg;
    logic [2:0] c_reg;
    logic [2:0] age_reg;
    wire        bypass = c_reg[1] == c_reg[0];
    // pins are judged only once a control write has had time to settle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            c_reg   <= 3'b000;
            age_reg <= 3'd0;
        end
        else
        begin
            if (s_axi_awready)
                a_reg <= s_axi_awaddr;
            if (s_axi_wready)
                d_reg <= {s_axi_wstrb[0], s_axi_wdata[2:0]};
            if (s_axi_bvalid && s_axi_bready && a_reg == 8'h00 && d_reg[3])
                c_reg <= d_reg[2:0];
            if (s_axi_awready || s_axi_bvalid)
                age_reg <= 3'd0;
            else if (age_reg != 3'd7)
                age_reg <= age_reg + 3'd1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awready && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arready && s_axi_rvalid;
    endsequence
    bypass_dir_a: assert property (age_reg == 3'd7 && bypass |-> rx_backplane_clock_oe && rx_frame_sync_oe)
        else $error("bypass pins not driven");
    clk_input_a: assert property (age_reg == 3'd7 && !bypass |-> !rx_backplane_clock_oe)
        else $error("clock pin driven in buffer mode");
    sync_dir_a: assert property (age_reg == 3'd7 && !bypass |-> rx_frame_sync_oe == !c_reg[2])
        else $error("sync direction wrong");
    reset_bypass_a: assert property ($rose(aresetn) |-> rx_backplane_clock_oe && rx_frame_sync_oe)
        else $error("not bypass after reset");
    write_resp_a: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write response late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_ans_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> rd_taken)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    slip_pulse_a: assert property (rx_buffer_slip |=> !rx_buffer_slip)
        else $error("slip flag too long");
endmodule // rsbmc_monitor

bind rsbmc_top rsbmc_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_backplane_clock_oe,
    .rx_frame_sync_oe, .rx_buffer_slip);

// File: tb/rsbmc_backplane.sv
module rsbmc_backplane (
    input  wire logic run,
    output logic      clk_o,
    output logic      sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    // clock stands still while run is low; idle sync toggles so no stale level survives
    initial
    begin
        clk_o = 1'b0;
        sync_o = 1'b0;
        #7;
        forever
        begin
            #160;
            if (run)
            begin
                clk_o = ~clk_o;
                n = clk_o ? (n + 1) % 8 : n;
                sync_o = clk_o ? (n == 0) : sync_o;
            end
            else
            begin
                clk_o = 1'b0;
                sync_o = ~sync_o;
            end
        end
    end
endmodule // rsbmc_backplane

// File: tb/tb.sv
`include "rsbmc_defs.vh"
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, line_data, line_clk, line_en, run, seen;
    logic        force_on, force_val;
    int          k0, k1, k2;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  m;
    logic [4:0]  lat;
    logic [33:0] exp_q[$];
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         rx_backplane_clock_o, rx_backplane_clock_oe, rx_frame_sync_o, rx_frame_sync_oe;
    wire         rx_data_out, rx_buffer_slip, m_clk, m_sync;
    wire         rx_backplane_clock_i = rx_backplane_clock_oe ? rx_backplane_clock_o : m_clk;
    wire         rx_frame_sync_i = rx_frame_sync_oe ? rx_frame_sync_o : m_sync;
    int          n_fail = 0;
    int          samples_checked = 0;

    rsbmc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .line_data, .line_clk, .line_sync(line_data), .rx_backplane_clock_i,
        .rx_backplane_clock_o, .rx_backplane_clock_oe, .rx_frame_sync_i, .rx_frame_sync_o,
        .rx_frame_sync_oe, .rx_data_out, .rx_buffer_slip);
    rsbmc_backplane u_far (.run(run), .clk_o(m_clk), .sync_o(m_sync));

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #2_000_000;
        n_fail++;
        end_sim;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK("bresp", `RSBMC_RESP_OKAY, s_axi_bresp)
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        exp_q.push_back(x);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // drain to an empty buffer and zero taps, then count cycles from the first
    // line rise carrying a one until that one shows on the data output
    task automatic lat_run(input logic [1:0] md, input logic [4:0] l, output int k);
        wr(`RSBMC_ADDR_CTRL, 32'(md));
        wr(`RSBMC_ADDR_LAT, 32'(l));
        force_on <= 1'b1;
        force_val <= 1'b0;
        line_en <= 1'b1;
        repeat (100) @(posedge aclk);
        line_en <= 1'b0;
        repeat (400) @(posedge aclk);
        force_val <= 1'b1;
        line_en <= 1'b1;
        @(posedge line_clk);
        k = 0;
        while (rx_data_out !== 1'b1 && k < 600)
        begin
            @(posedge aclk);
            k++;
        end
        line_en <= 1'b0;
    endtask

    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
        begin
            `CHK("rdata", exp_q[0][31:0], s_axi_rdata)
            `CHK("rresp", exp_q[0][33:32], s_axi_rresp)
            void'(exp_q.pop_front());
        end
    end

    // line clock of 320 ns built from the bench clock; a fresh bit on each rise
    initial
    forever
    begin
        repeat (4) @(posedge aclk);
        if (line_en) line_clk <= ~line_clk;
        if (line_en && !line_clk) line_data <= force_on ? force_val : 1'($urandom);
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {line_data, line_clk, line_en, run, force_on, force_val} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        seen = $urandom(32'h050b);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`RSBMC_ADDR_CTRL, 34'h0);
        rd(`RSBMC_ADDR_LAT, 34'h4);
        rd(8'h0c, {`RSBMC_RESP_SLVERR, 32'h0000_0000});
        wr(`RSBMC_ADDR_LAT, 32'hffff_ffff);
        rd(`RSBMC_ADDR_LAT, 34'h1f);
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:0];
            wr(`RSBMC_ADDR_CTRL, ($urandom & 32'hffff_fff8) | 32'(m));
            repeat (10) @(posedge aclk);
            `CHK("clk_oe", m[1] == m[0], rx_backplane_clock_oe)
            `CHK("sync_oe", m[1] == m[0] || !m[2], rx_frame_sync_oe)
            rd(`RSBMC_ADDR_STATUS, m[1] == m[0] ? 34'h1 : (m[1] ? 34'h4 : 34'h2));
            rd(`RSBMC_ADDR_CTRL, 34'(m));
        end
        wr(`RSBMC_ADDR_CTRL, 32'h0000_0000);
        line_en <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge line_clk);
            seen = line_data;
            repeat (4) @(posedge aclk);
            #1 `CHK("bypass_data", seen, rx_data_out)
            `CHK("bypass_sync", seen, rx_frame_sync_o)
            `CHK("bypass_clk", 1'b0, rx_backplane_clock_o)
        end
        @(posedge aclk);
        wr(`RSBMC_ADDR_CTRL, 32'(`RSBMC_MODE_SLIP));
        seen = 1'b0;
        repeat (200) @(posedge aclk) seen |= rx_buffer_slip;
        `CHK("slip", 1'b1, seen)
        line_en <= 1'b0;
        rd(`RSBMC_ADDR_STATUS, 34'h22);
        run <= 1'b1;
        repeat (100) @(posedge aclk);
        rd(`RSBMC_ADDR_STATUS, 34'h2);
        wr(`RSBMC_ADDR_CTRL, 32'(`RSBMC_MODE_FIFO));
        lat = 5'($urandom);
        wr(`RSBMC_ADDR_LAT, 32'(lat));
        rd(`RSBMC_ADDR_LAT, 34'(lat));
        lat_run(`RSBMC_MODE_FIFO, 5'h00, k0);
        lat_run(`RSBMC_MODE_FIFO, lat, k1);
        `CHK("fifo_latency", 8 * lat, k1 - k0)
        lat_run(`RSBMC_MODE_SLIP, lat | 5'h01, k2);
        `CHK("slip_ignores_lat", k0, k2)
        end_sim;
    end
endmodule // tb
